/* design/mas_fifo.v */
// Character FIFO with a registered read stage, valid and ready on both sides.
`timescale 1ns/1ps
module mas_fifo #(
    parameter W = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output reg o_out_valid_q,
    input wire i_out_ready,
    output reg [W-1:0] o_out_data_q
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    // Full is honest: ready drops at DEPTH stored words so the source stalls.
    assign o_in_ready = (count_q != DEPTH[AW:0]);
    assign push = i_in_valid && o_in_ready;
    assign pop = (count_q != {(AW+1){1'b0}}) && (!o_out_valid_q || i_out_ready);

    // Storage is written without reset; only the pointers, count and output stage need a defined value.
    always @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr_q] <= i_in_data;
        end
    end

    // Pointer, count and output stage bookkeeping.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            o_out_valid_q <= 1'b0;
            o_out_data_q <= {W{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
                o_out_data_q <= mem[rd_ptr_q];
                o_out_valid_q <= 1'b1;
            end else if (i_out_ready) begin
                o_out_valid_q <= 1'b0;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

/* design/mas_slave.v */
// Slave-side ASCII frame handler: parses requests, checks the sum, answers.
//
// Function
// R1 - Frames: colon, hex digit pairs, CR LF.
// R2 - Function 03h reads consecutive holding registers.
// R3 - Function 06h writes one addressed register.
// R4 - Recognise 10h and 17h multi-register functions.
// R5 - Broadcast single writes are ignored, unanswered.
// R6 - Check sum excludes colon and CR LF.
// R7 - Sender appends check value; receiver recomputes.
// R8 - Check mismatch discards request, no answer.
// R9 - Check is two's complement of byte sum.
// R10 - Read request: address, 03, start, quantity, check.
// R11 - Read answer: address, code, count, values, check.
// R12 - Sixteen-bit fields go high byte first.
// R13 - Return registers consecutively from start address.
// R14 - Map temperature, pressure, status, two alarm words.
// R15 - Write request: address, 06, register, value, check.
// R16 - Write answer echoes address, register, value.
// R17 - No answer without colon and CR LF.
// R18 - Colon discards prior characters, restarts frame.
// R19 - Slave address 1 to 99, default 1.
// R20 - Transmit only in reply to requests.
// R21 - Answer only own slave address.
// R22 - Drop unknown function codes without side effects.
`timescale 1ns/1ps
`include "mas_defs.vh"
module mas_slave (
    input wire i_mclk,
    input wire i_rst_n,
    input wire [7:0] i_rx_data,
    input wire i_rx_valid,
    output wire [7:0] o_tx_data,
    output wire o_tx_valid,
    input wire i_tx_ready,
    input wire [7:0] i_slave_addr,
    input wire [15:0] i_temp,
    input wire [15:0] i_press,
    input wire [15:0] i_status,
    input wire [15:0] i_alarm1,
    input wire [15:0] i_alarm2,
    output reg o_wr_stb_q,
    output reg [15:0] o_wr_addr_q,
    output reg [15:0] o_wr_data_q,
    output reg o_multi_stb_q,
    output reg [7:0] o_multi_fc_q,
    output reg o_chk_err_q
);
    localparam [1:0] RX_HUNT = 2'b00;
    localparam [1:0] RX_HI = 2'b01;
    localparam [1:0] RX_LO = 2'b10;
    localparam [1:0] RX_LF = 2'b11;
    localparam [2:0] TX_IDLE = 3'b000;
    localparam [2:0] TX_COLON = 3'b001;
    localparam [2:0] TX_HI = 3'b010;
    localparam [2:0] TX_LO = 3'b011;
    localparam [2:0] TX_CR = 3'b100;
    localparam [2:0] TX_LF = 3'b101;

    // Hex digit decode: bit 4 flags a legal digit, lower case is accepted too.
    function [4:0] hex_val;
        input [7:0] c;
        begin
            if (c >= 8'h30 && c <= 8'h39) begin
                hex_val = {1'b1, c[3:0]};
            end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
                hex_val = {1'b1, c[3:0] + 4'h9};
            end else begin
                hex_val = 5'h00;
            end
        end
    endfunction

    // Nibble to upper-case ASCII hex digit.
    function [7:0] to_hex;
        input [3:0] n;
        begin
            if (n < 4'hA) begin
                to_hex = {4'h3, n};
            end else begin
                to_hex = {4'h4, n - 4'h9};
            end
        end
    endfunction

    // Register map; reserved and unmapped words read as zero.
    // The live values come in as arguments so that the caller's block wakes when they move.
    function [15:0] rd_reg;
        input [15:0] a;
        input [15:0] v_temp;
        input [15:0] v_press;
        input [15:0] v_status;
        input [15:0] v_alarm1;
        input [15:0] v_alarm2;
        begin
            case (a)
                `MAS_REG_TEMP: rd_reg = v_temp; // R14
                `MAS_REG_PRESS: rd_reg = v_press; // R14
                `MAS_REG_STATUS: rd_reg = v_status; // R14
                `MAS_REG_ALARM1: rd_reg = v_alarm1; // R14
                `MAS_REG_ALARM2: rd_reg = v_alarm2; // R14
                default: rd_reg = 16'h0000;
            endcase
        end
    endfunction

    reg [7:0] own_q;
    reg [1:0] rx_st_q;
    reg [3:0] nib_q;
    reg [7:0] rx_buf_q [0:7];
    reg [3:0] rx_cnt_q;
    reg [7:0] rx_sum_q;
    reg [2:0] tx_st_q;
    reg [7:0] tx_idx_q;
    reg [7:0] tx_len_q;
    reg [7:0] tx_sum_q;
    reg [7:0] req_fc_q;
    reg [15:0] req_a_q;
    reg [15:0] req_d_q;
    reg [7:0] cur_byte;
    reg [7:0] fifo_data;
    reg fifo_valid;
    reg [15:0] word;
    reg [7:0] widx;
    wire fifo_ready;
    wire [4:0] hv;
    wire [7:0] rx_byte;
    wire lf_seen;
    wire frame_ok;
    wire [7:0] fc;
    wire [15:0] f_a;
    wire [15:0] f_d;
    wire qty_ok;

    assign hv = hex_val(i_rx_data);
    assign rx_byte = {nib_q, hv[3:0]};
    assign lf_seen = i_rx_valid && (rx_st_q == RX_LF) && (i_rx_data == `MAS_CH_LF);
    assign fc = rx_buf_q[1];
    assign f_a = {rx_buf_q[2], rx_buf_q[3]}; // R12
    assign f_d = {rx_buf_q[4], rx_buf_q[5]}; // R12
    // Whole frame plus check byte sums to zero when the check matches.
    assign frame_ok = (rx_cnt_q == `MAS_REQ_LEN) && (rx_sum_q == 8'h00) // R7 R8 R9
        && (rx_buf_q[0] == own_q) // R21
        && (rx_buf_q[0] != `MAS_ADDR_BCAST); // R5
    assign qty_ok = (f_d != 16'h0000) && (f_d <= `MAS_QTY_MAX);

    // Out-of-range configured addresses fall back to the default identity.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            own_q <= `MAS_ADDR_DEF;
        end else if (i_slave_addr >= `MAS_ADDR_MIN && i_slave_addr <= `MAS_ADDR_MAX) begin
            own_q <= i_slave_addr; // R19
        end else begin
            own_q <= `MAS_ADDR_DEF; // R19
        end
    end

    // Receive parser; the byte count saturates at 8, one past a request, so long frames fail length.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rx_st_q <= RX_HUNT;
            nib_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            rx_sum_q <= 8'h00;
        end else if (i_rx_valid) begin
            if (i_rx_data == `MAS_CH_COLON) begin
                rx_st_q <= RX_HI; // R18
                rx_cnt_q <= 4'h0; // R18
                rx_sum_q <= 8'h00; // R6
            end else begin
                case (rx_st_q)
                    RX_HI: begin
                        if (i_rx_data == `MAS_CH_CR) begin
                            rx_st_q <= RX_LF; // R1
                        end else if (hv[4]) begin
                            nib_q <= hv[3:0];
                            rx_st_q <= RX_LO;
                        end else begin
                            rx_st_q <= RX_HUNT; // R17
                        end
                    end
                    RX_LO: begin
                        if (hv[4]) begin
                            rx_sum_q <= rx_sum_q + rx_byte; // R9
                            if (rx_cnt_q != `MAS_BUF_MAX) begin
                                rx_cnt_q <= rx_cnt_q + 4'h1;
                            end
                            rx_st_q <= RX_HI;
                        end else begin
                            rx_st_q <= RX_HUNT; // R1
                        end
                    end
                    RX_LF: begin
                        rx_st_q <= RX_HUNT; // R17
                    end
                    default: begin
                        rx_st_q <= RX_HUNT;
                    end
                endcase
            end
        end
    end

    // Byte store; kept apart so the array needs no reset.
    always @(posedge i_mclk) begin
        if (i_rx_valid && rx_st_q == RX_LO && hv[4] && rx_cnt_q != `MAS_BUF_MAX) begin
            rx_buf_q[rx_cnt_q[2:0]] <= rx_byte;
        end
    end

    // Byte to send at the current index; check byte comes last.
    always @* begin
        widx = tx_idx_q - 8'h03;
        word = rd_reg(req_a_q + {9'h000, widx[7:1]}, i_temp, i_press, i_status, // R13
            i_alarm1, i_alarm2);
        cur_byte = 8'h00;
        if (tx_idx_q == tx_len_q) begin
            cur_byte = 8'h00 - tx_sum_q; // R7 R9
        end else if (tx_idx_q == 8'h00) begin
            cur_byte = own_q;
        end else if (tx_idx_q == 8'h01) begin
            cur_byte = req_fc_q;
        end else if (req_fc_q == `MAS_FC_WRITE) begin
            case (tx_idx_q)
                8'h02: cur_byte = req_a_q[15:8]; // R16 R12
                8'h03: cur_byte = req_a_q[7:0]; // R16
                8'h04: cur_byte = req_d_q[15:8]; // R16
                8'h05: cur_byte = req_d_q[7:0]; // R16
                default: cur_byte = 8'h00;
            endcase
        end else if (tx_idx_q == 8'h02) begin
            cur_byte = {req_d_q[6:0], 1'b0}; // R11
        end else begin
            cur_byte = widx[0] ? word[7:0] : word[15:8]; // R11 R12
        end
    end

    // Character selection for the outgoing FIFO.
    always @* begin
        fifo_valid = 1'b1;
        case (tx_st_q)
            TX_COLON: fifo_data = `MAS_CH_COLON; // R1
            TX_HI: fifo_data = to_hex(cur_byte[7:4]); // R1
            TX_LO: fifo_data = to_hex(cur_byte[3:0]);
            TX_CR: fifo_data = `MAS_CH_CR;
            TX_LF: fifo_data = `MAS_CH_LF;
            default: begin
                fifo_data = 8'h00;
                fifo_valid = 1'b0;
            end
        endcase
    end

    // Request acceptance and response sequencing; transmit starts only from a valid request.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            tx_st_q <= TX_IDLE;
            tx_idx_q <= 8'h00;
            tx_len_q <= 8'h00;
            tx_sum_q <= 8'h00;
            req_fc_q <= 8'h00;
            req_a_q <= 16'h0000;
            req_d_q <= 16'h0000;
            o_wr_stb_q <= 1'b0;
            o_wr_addr_q <= 16'h0000;
            o_wr_data_q <= 16'h0000;
            o_multi_stb_q <= 1'b0;
            o_multi_fc_q <= 8'h00;
            o_chk_err_q <= 1'b0;
        end else begin
            o_wr_stb_q <= 1'b0;
            o_multi_stb_q <= 1'b0;
            o_chk_err_q <= lf_seen && (rx_sum_q != 8'h00); // R8
            case (tx_st_q)
                TX_IDLE: begin
                    // A request arriving before the sequencer is back in TX_IDLE is dropped; one arriving while the FIFO still drains is taken.
                    if (lf_seen && frame_ok) begin // R20
                        req_fc_q <= fc;
                        req_a_q <= f_a;
                        req_d_q <= f_d;
                        tx_idx_q <= 8'h00;
                        tx_sum_q <= 8'h00;
                        if (fc == `MAS_FC_READ && qty_ok) begin // R22
                            tx_len_q <= {f_d[6:0], 1'b0} + 8'h03; // R2 R11
                            tx_st_q <= TX_COLON;
                        end else if (fc == `MAS_FC_WRITE) begin
                            o_wr_stb_q <= 1'b1; // R3
                            o_wr_addr_q <= f_a; // R3
                            o_wr_data_q <= f_d;
                            tx_len_q <= 8'h06;
                            tx_st_q <= TX_COLON; // R16
                        end else if (fc == `MAS_FC_MULTI_WR || fc == `MAS_FC_MULTI_RW) begin
                            o_multi_stb_q <= 1'b1; // R4
                            o_multi_fc_q <= fc; // R4
                        end
                    end
                end
                TX_COLON: begin
                    if (fifo_ready) begin
                        tx_st_q <= TX_HI;
                    end
                end
                TX_HI: begin
                    if (fifo_ready) begin
                        tx_st_q <= TX_LO;
                    end
                end
                TX_LO: begin
                    if (fifo_ready) begin
                        tx_sum_q <= tx_sum_q + cur_byte; // R6 R9
                        tx_idx_q <= tx_idx_q + 8'h01;
                        tx_st_q <= (tx_idx_q == tx_len_q) ? TX_CR : TX_HI;
                    end
                end
                TX_CR: begin
                    if (fifo_ready) begin
                        tx_st_q <= TX_LF;
                    end
                end
                TX_LF: begin
                    if (fifo_ready) begin
                        tx_st_q <= TX_IDLE;
                    end
                end
                default: begin
                    tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    // The FIFO absorbs a stalled line; its ready holds the sequencer above.
    mas_fifo #(
        .W(`MAS_FIFO_W),
        .DEPTH(`MAS_FIFO_DEPTH),
        .AW(`MAS_FIFO_AW)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_valid(fifo_valid),
        .o_in_ready(fifo_ready),
        .i_in_data(fifo_data),
        .o_out_valid_q(o_tx_valid),
        .i_out_ready(i_tx_ready),
        .o_out_data_q(o_tx_data)
    );
endmodule

/* include/mas_defs.vh */
// Constants for the serial register-access frame handler.
`ifndef MAS_DEFS_VH
`define MAS_DEFS_VH
`define MAS_CH_COLON 8'h3A
`define MAS_CH_CR 8'h0D
`define MAS_CH_LF 8'h0A
`define MAS_FC_READ 8'h03
`define MAS_FC_WRITE 8'h06
`define MAS_FC_MULTI_WR 8'h10
`define MAS_FC_MULTI_RW 8'h17
`define MAS_REG_TEMP 16'h0000
`define MAS_REG_RSVD1 16'h0001
`define MAS_REG_PRESS 16'h0002
`define MAS_REG_RSVD3 16'h0003
`define MAS_REG_STATUS 16'h0004
`define MAS_REG_ALARM1 16'h0005
`define MAS_REG_ALARM2 16'h0006
`define MAS_ADDR_MIN 8'h01
`define MAS_ADDR_MAX 8'h63
`define MAS_ADDR_DEF 8'h01
`define MAS_ADDR_BCAST 8'h00
`define MAS_REQ_LEN 4'h7
`define MAS_BUF_MAX 4'h8
`define MAS_QTY_MAX 16'h007D
`define MAS_FIFO_W 8
`define MAS_FIFO_DEPTH 16
`define MAS_FIFO_AW 4
`endif

/* sim/mas_host.sv */
// Host master model: sends framed requests and collects the answer characters.
`timescale 1ns/1ps
module mas_host (
    input wire i_mclk,
    output reg [7:0] o_rx_data,
    output reg o_rx_valid,
    input wire [7:0] i_tx_data,
    input wire i_tx_valid,
    output reg o_tx_ready
);
    logic [7:0] got[$];
    bit slow = 1'b0;
    // Idle line at time zero.
    initial begin
        o_rx_data = 8'h00;
        o_rx_valid = 1'b0;
        o_tx_ready = 1'b1;
    end
    // Hex digit of one nibble, upper case.
    function automatic [7:0] hx(input [3:0] n);
        hx = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // Builds a whole frame; the check byte is the negated byte sum, colon and CR LF left out.
    task automatic mk(input logic [7:0] b[$], output logic [7:0] f[$]);
        logic [7:0] s;
        s = 8'h00;
        f = {8'h3A};
        foreach (b[i]) begin
            s = s + b[i];
            f.push_back(hx(b[i][7:4]));
            f.push_back(hx(b[i][3:0]));
        end
        s = -s;
        f.push_back(hx(s[7:4]));
        f.push_back(hx(s[3:0]));
        f.push_back(8'h0D);
        f.push_back(8'h0A);
    endtask
    // Sends back to back; the released data line shows the inverse so stale values never match.
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(negedge i_mclk);
            o_rx_data <= f[i];
            o_rx_valid <= 1'b1;
        end
        @(negedge i_mclk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~o_rx_data;
    endtask
    // Takes a character on each edge where valid and ready meet.
    always @(posedge i_mclk) begin
        if (i_tx_valid && o_tx_ready)
            got.push_back(i_tx_data);
    end
    // Ready toggles in slow mode so the buffer backs up.
    always @(negedge i_mclk) begin
        o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    end
endmodule

/* sim/mas_slave_properties.sv */
// Concurrent checks on the frame handler's ports.
`timescale 1ns/1ps
module mas_slave_props (
    input wire i_mclk,
    input wire i_rst_n,
    input wire [7:0] o_tx_data,
    input wire o_tx_valid,
    input wire i_tx_ready,
    input wire o_wr_stb_q,
    input wire [15:0] o_wr_addr_q,
    input wire [15:0] o_wr_data_q,
    input wire o_multi_stb_q,
    input wire [7:0] o_multi_fc_q,
    input wire o_chk_err_q
);
    // Every check shares the one clock and is quiet while reset is held.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    property p_tx_hold;
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
    endproperty
    property p_cr_lf;
        o_tx_valid && i_tx_ready && o_tx_data == 8'h0D |=> ##[0:2] (o_tx_valid && o_tx_data == 8'h0A);
    endproperty
    property p_wr_tx;
        o_wr_stb_q |-> ##2 o_tx_valid;
    endproperty
    property p_wr_pulse;
        o_wr_stb_q |=> !o_wr_stb_q;
    endproperty
    property p_wr_hold;
        !o_wr_stb_q |-> $stable(o_wr_addr_q) && $stable(o_wr_data_q);
    endproperty
    property p_multi;
        o_multi_stb_q |-> (o_multi_fc_q == 8'h10 || o_multi_fc_q == 8'h17) ##1 !o_multi_stb_q;
    endproperty
    property p_multi_silent;
        o_multi_stb_q && !o_tx_valid |=> !o_tx_valid;
    endproperty
    property p_err_excl;
        o_chk_err_q |-> !o_wr_stb_q && !o_multi_stb_q ##1 !o_chk_err_q;
    endproperty
    property p_err_silent;
        o_chk_err_q && !o_tx_valid |=> !o_tx_valid;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx char changed while stalled");
    a_cr_lf: assert property (p_cr_lf) else $error("CR not followed by LF");
    a_wr_tx: assert property (p_wr_tx) else $error("write not answered");
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    a_wr_hold: assert property (p_wr_hold) else $error("write fields moved");
    a_multi: assert property (p_multi) else $error("bad multi strobe");
    a_multi_silent: assert property (p_multi_silent) else $error("multi answered");
    a_err_excl: assert property (p_err_excl) else $error("check error with action");
    a_err_silent: assert property (p_err_silent) else $error("bad frame answered");
    // Main scenarios that the bench is expected to reach.
    c_wr: cover property (o_wr_stb_q);
    c_multi: cover property (o_multi_stb_q);
    c_err: cover property (o_chk_err_q);
    c_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule
bind mas_slave mas_slave_props u_props (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready),
    .o_wr_stb_q(o_wr_stb_q),
    .o_wr_addr_q(o_wr_addr_q),
    .o_wr_data_q(o_wr_data_q),
    .o_multi_stb_q(o_multi_stb_q),
    .o_multi_fc_q(o_multi_fc_q),
    .o_chk_err_q(o_chk_err_q)
);

/* sim/tb_mas_slave.sv */
// Self-checking bench for the frame handler, driven through the host model.
`timescale 1ns/1ps
module tb_mas_slave;
    reg i_mclk = 1'b0;
    reg i_rst_n = 1'b0;
    reg [7:0] i_slave_addr = 8'h01;
    reg [15:0] i_temp = 16'h00EE;
    reg [15:0] i_press = 16'h000D;
    reg [15:0] i_status = 16'h0201;
    reg [15:0] i_alarm1 = 16'h1234;
    reg [15:0] i_alarm2 = 16'hABCD;
    wire [7:0] rx_data, tx_data, multi_fc;
    wire rx_valid, tx_valid, tx_ready, wr_stb, multi_stb, chk_err;
    wire [15:0] wr_addr, wr_data;
    integer failures = 0;
    integer samples_checked = 0;
    integer n_wr = 0, n_multi = 0, n_err = 0;
    logic [7:0] f[$], e[$], none[$];
    mas_host u_host (
        .i_mclk(i_mclk),
        .o_rx_data(rx_data),
        .o_rx_valid(rx_valid),
        .i_tx_data(tx_data),
        .i_tx_valid(tx_valid),
        .o_tx_ready(tx_ready)
    );
    mas_slave uut (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_rx_data(rx_data),
        .i_rx_valid(rx_valid),
        .o_tx_data(tx_data),
        .o_tx_valid(tx_valid),
        .i_tx_ready(tx_ready),
        .i_slave_addr(i_slave_addr),
        .i_temp(i_temp),
        .i_press(i_press),
        .i_status(i_status),
        .i_alarm1(i_alarm1),
        .i_alarm2(i_alarm2),
        .o_wr_stb_q(wr_stb),
        .o_wr_addr_q(wr_addr),
        .o_wr_data_q(wr_data),
        .o_multi_stb_q(multi_stb),
        .o_multi_fc_q(multi_fc),
        .o_chk_err_q(chk_err)
    );
    // Clock at 50 MHz.
    always #10 i_mclk = ~i_mclk;
    // Counts strobes so that silent scenarios can show nothing fired.
    // Gated by reset, since the strobes are unknown before the first reset edge.
    always @(posedge i_mclk) begin
        if (i_rst_n) begin
            n_wr <= n_wr + wr_stb;
            n_multi <= n_multi + multi_stb;
            n_err <= n_err + chk_err;
        end
    end
    task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        samples_checked++;
        if (got !== ex) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task end_sim;
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Sends a request, spoiled as asked, then checks the answer or the silence.
    task automatic run(input logic [7:0] b[$], input int bad, input logic [7:0] r[$]);
        int k;
        u_host.got.delete();
        u_host.mk(b, f);
        case (bad)
            1: f[f.size()-3] ^= 8'h01;
            2: f.delete(0);
            3: f.delete(f.size()-1);
            4: f.push_front(8'h37);
            5: foreach (f[i]) f[i] = (f[i] > 8'h40) ? (f[i] | 8'h20) : f[i];
            default: k = 0;
        endcase
        u_host.send(f);
        if (r.size() == 0) begin
            repeat (80) @(posedge i_mclk);
            chk("silent", 16'h0000, u_host.got.size());
        end else begin
            u_host.mk(r, e);
            k = 0;
            while (u_host.got.size() < e.size() && k < 500) begin
                @(posedge i_mclk);
                k++;
            end
            repeat (4) @(posedge i_mclk);
            chk("length", e.size(), u_host.got.size());
            foreach (e[i]) chk("char", e[i], u_host.got[i]);
        end
    endtask
    // Main sequence; waits cover the full answer before the next request goes out.
    initial begin
        repeat (5) @(negedge i_mclk);
        i_rst_n <= 1'b1;
        @(negedge i_mclk);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0, '{8'h01, 8'h03, 8'h02, 8'h00, 8'hEE});
        u_host.slow = 1'b1;
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h07}, 0, '{8'h01, 8'h03, 8'h0E, 8'h00, 8'hEE,
            8'h00, 8'h00, 8'h00, 8'h0D, 8'h00, 8'h00, 8'h02, 8'h01, 8'h12, 8'h34, 8'hAB, 8'hCD});
        u_host.slow = 1'b0;
        @(negedge i_mclk);
        i_temp <= 16'h00D4;
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0, '{8'h01, 8'h03, 8'h02, 8'h00, 8'hD4});
        run('{8'h01, 8'h06, 8'h00, 8'h0C, 8'h00, 8'h01}, 5, '{8'h01, 8'h06, 8'h00, 8'h0C, 8'h00, 8'h01});
        chk("wr_addr", 16'h000C, wr_addr);
        chk("wr_data", 16'h0001, wr_data);
        run('{8'h00, 8'h06, 8'h00, 8'h0C, 8'h00, 8'h02}, 0, none);
        chk("wr_count", 16'h0001, n_wr);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1, none);
        chk("err_count", 16'h0001, n_err);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 2, none);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 3, none);
        run('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 4, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h0D});
        run('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0, none);
        @(negedge i_mclk);
        i_slave_addr <= 8'h05;
        run('{8'h05, 8'h03, 8'h00, 8'h06, 8'h00, 8'h01}, 0, '{8'h05, 8'h03, 8'h02, 8'hAB, 8'hCD});
        @(negedge i_mclk);
        i_slave_addr <= 8'h64;
        run('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01}, 0, '{8'h01, 8'h03, 8'h02, 8'h02, 8'h01});
        for (int j = 0; j < 2; j++) begin
            run('{8'h01, j ? 8'h17 : 8'h10, 8'h00, 8'h0B, 8'h00, 8'h02}, 0, none);
            chk("multi_fc", j ? 16'h0017 : 16'h0010, multi_fc);
            chk("multi_count", j + 1, n_multi);
        end
        run('{8'h01, 8'h05, 8'h00, 8'h0C, 8'h00, 8'h03}, 0, none);
        chk("wr_count", 16'h0001, n_wr);
        chk("multi_count", 16'h0002, n_multi);
        end_sim();
    end
    // Watchdog: the sequence needs about 1200 cycles, so 20000 means a hang.
    initial begin
        #400000;
        failures++;
        end_sim();
    end
endmodule
